// File: inc/port_wake_pkg.sv
// Purpose: Shared constants for the port edge interrupt and wake unit
// Assumes: 8-bit port, 11-bit program counter, 8-bit core registers
// Notes:   Selector codes are the values the core holds in its port
//          access selector when it writes the port configuration location
package port_wake_pkg;

  localparam int PORT_W = 8;
  localparam int PC_W = 11;
  localparam int DATA_W = 8;

  // Port access selector codes
  localparam logic [7:0] SEL_PENDING_XCHG = 8'h09;
  localparam logic [7:0] SEL_EDGE_POL = 8'h0A;
  localparam logic [7:0] SEL_WAKE_EN = 8'h0B;
  localparam logic [7:0] SEL_PIN_DIR = 8'h0F;

  // Values after reset
  localparam logic [7:0] WAKE_EN_RST = 8'hFF;
  localparam logic [7:0] EDGE_POL_RST = 8'hFF;
  localparam logic [7:0] PIN_DIR_RST = 8'hFF;
  // Pending is undefined to software; hardware needs some constant
  localparam logic [7:0] PENDING_RST = 8'h00;

  // Program counter targets
  localparam logic [10:0] IRQ_VECTOR = 11'h000;
  localparam logic [10:0] RESET_VECTOR = 11'h7FF;

  // Timer rollover detection
  localparam logic [7:0] RTC_MAX = 8'hFF;
  localparam logic [7:0] RTC_ZERO = 8'h00;

  // Page select bits 7:5 of the flags register
  localparam logic [7:0] PAGE_SEL_MASK = 8'hE0;

  // Interrupt sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_SERVICE = 2'b10
  } irq_state_e;

endpackage

// File: testbench/core_timer_model.sv
// Purpose: Core-side real-time counter feeding the unit
// Assumes: Counter steps once per instruction cycle
// Notes:   Add-on-return lands in the same step as the tick
`timescale 1ns/1ps
`default_nettype none
module core_timer_model (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_rtc_add,
  input wire logic [7:0] i_rtc_add_value,
  output logic [7:0] o_rtc_value
);
  // Free-running count, so rollovers come every 256 cycles unless an add-on-return lands
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rtc_value <= 8'h00;
    end else if (i_rtc_add) begin
      o_rtc_value <= o_rtc_value + i_rtc_add_value + 8'h01;
    end else begin
      o_rtc_value <= o_rtc_value + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: testbench/port_edge_interrupt_wakeup_unit_test.sv
// Purpose: Random and corner-case bench for the port interrupt unit
// Assumes: Inputs change on the falling clock edge
// Notes:   Expected context values are kept by the bench itself
`timescale 1ns/1ps
`default_nettype none
module port_edge_interrupt_wakeup_unit_test;
  import port_wake_pkg::*;
  logic clk, rst, cfg_wr, rtc_en, sleep, ack, ret_p, ret_a, pb;
  logic [7:0] pins, sel, acc, bank, flags, rtc, s_acc, s_bank, s_flags;
  logic [10:0] pc, s_pc, pcv;
  logic req, insv, pcl, fll, ctx, radd, xv, wake;
  logic [7:0] flv, bkv, acv, rav, xd, pend, en, pol, dir;
  logic xv_s;
  logic [7:0] xd_s;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int p, q, k;

  port_edge_interrupt_wakeup_unit dut (.i_sys_clk(clk), .i_sys_rst(rst),
    .i_port_pins(pins), .i_cfg_wr(cfg_wr), .i_port_sel(sel), .i_acc(acc),
    .i_bank_sel(bank), .i_flags(flags), .i_pc(pc), .i_rtc_value(rtc),
    .i_rtc_irq_en(rtc_en), .i_sleep(sleep), .i_irq_ack(ack),
    .i_irq_return(ret_p), .i_irq_return_add_acc(ret_a), .o_irq_req(req),
    .o_in_service(insv), .o_pc_load(pcl), .o_pc_value(pcv),
    .o_flags_load(fll), .o_flags_value(flv), .o_ctx_restore(ctx),
    .o_bank_value(bkv), .o_acc_value(acv), .o_rtc_add(radd),
    .o_rtc_add_value(rav), .o_xchg_valid(xv), .o_xchg_data(xd),
    .o_wake(wake), .o_pin_wake_pending(pend), .o_pin_wake_enable(en),
    .o_pin_edge_polarity(pol), .o_pin_dir(dir));

  core_timer_model timer (.i_sys_clk(clk), .i_sys_rst(rst),
    .i_rtc_add(radd), .i_rtc_add_value(rav), .o_rtc_value(rtc));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; a full run needs well under 5000 cycles
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  task automatic results();
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [10:0] e,
                     input logic [10:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One write to the port configuration location; swap answer captured
  task automatic cfg(input logic [7:0] s, input logic [7:0] d);
    cfg_wr = 1'b1;
    sel = s;
    acc = d;
    tick(1);
    cfg_wr = 1'b0;
    xv_s = xv;
    xd_s = xd;
    // Idle cycle, so a following write never re-raises the strobe at once
    tick(1);
  endtask

  task automatic wait_req(input int n);
    k = 0;
    while (req !== 1'b1 && k < n) begin
      tick(1);
      k++;
    end
  endtask

  // Acknowledge with random live context, then scramble PC, flags and bank
  task automatic irq_ack();
    s_pc = 11'($urandom);
    s_flags = 8'($urandom);
    s_bank = 8'($urandom);
    s_acc = 8'($urandom);
    pc = s_pc;
    flags = s_flags;
    bank = s_bank;
    acc = s_acc;
    ack = 1'b1;
    tick(1);
    ack = 1'b0;
    chk("pc_load", 1, pcl);
    chk("pc_value", IRQ_VECTOR, pcv);
    chk("flags_load", 1, fll);
    chk("flags_value", s_flags & ~PAGE_SEL_MASK, flv);
    chk("in_service", 1, insv);
    chk("irq_req", 0, req);
    pc = ~s_pc;
    flags = ~s_flags;
    bank = ~s_bank;
  endtask

  task automatic irq_ret(input bit a);
    logic [7:0] w;
    w = 8'($urandom);
    acc = w;
    ret_p = !a;
    ret_a = a;
    tick(1);
    ret_p = 1'b0;
    ret_a = 1'b0;
    chk("ret_pc", s_pc, pcv);
    chk("ret_flags", s_flags, flv);
    chk("ret_restore", 1, ctx);
    chk("ret_bank", s_bank, bkv);
    chk("ret_acc", s_acc, acv);
    chk("ret_in_service", 0, insv);
    if (a) chk("rtc_add_value", w, rav);
    chk("rtc_add", a, radd);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {cfg_wr, rtc_en, sleep, ack, ret_p, ret_a} = '0;
    {pins, sel, acc, bank, flags} = '0;
    pc = '0;
    rst = 1'b1;
    p = $urandom(53);
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    tick(1);
    chk("enable_rst", WAKE_EN_RST, en);
    chk("polarity_rst", EDGE_POL_RST, pol);
    chk("pc_rst", RESET_VECTOR, pcv);
    cfg(SEL_PIN_DIR, 8'h5A);
    cfg(8'h0C, 8'h00);
    tick(2);
    chk("dir", 8'h5A, dir);
    chk("enable_kept", 8'hFF, en);
    chk("polarity_kept", 8'hFF, pol);
    for (int i = 0; i < 8; i++) begin
      p = $urandom % 8;
      q = (p + 1) % 8;
      pb = 1'($urandom);
      pins = {7'h00, pb} << p;
      tick(8);
      // Polarity, then clear, then enable
      cfg(SEL_EDGE_POL, {7'h00, pb} << p);
      cfg(SEL_PENDING_XCHG, 8'h00);
      cfg(SEL_WAKE_EN, ~((8'h01 << p) | (8'h01 << q)));
      tick(2);
      pins[p] = ~pb;
      wait_req(20);
      chk("irq_req", 1, req);
      tick(1);
      chk("pending", 1, pend[p]);
      irq_ack();
      pins[q] = 1'b1;
      tick(8);
      chk("pend_in_service", 1, pend[q]);
      chk("req_in_service", 0, req);
      irq_ret(1'($urandom));
      // Second selected edge while its pending bit is still set
      pins[p] = pb;
      tick(8);
      pins[p] = ~pb;
      tick(8);
      chk("req_after_ret", 0, req);
      cfg(SEL_PENDING_XCHG, 8'h00);
      chk("xchg_valid", 1, xv_s);
      chk("xchg_data", (8'h01 << p) | (8'h01 << q), xd_s);
      cfg(SEL_WAKE_EN, 8'hFF);
      pins[p] = pb;
      tick(8);
      pins[p] = ~pb;
      tick(8);
      chk("req_disabled", 0, req);
      chk("pend_disabled", 1, pend[p]);
    end
    // Wake from power-down on a falling pin
    pins = 8'h01;
    cfg(SEL_EDGE_POL, 8'hFF);
    tick(8);
    cfg(SEL_PENDING_XCHG, 8'h00);
    cfg(SEL_WAKE_EN, 8'hFE);
    sleep = 1'b1;
    pins = 8'h00;
    k = 0;
    while (wake !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    chk("wake", 1, wake);
    chk("wake_pc", RESET_VECTOR, pcv);
    chk("wake_pc_load", 1, pcl);
    chk("wake_req", 0, req);
    sleep = 1'b0;
    cfg(SEL_WAKE_EN, 8'hFF);
    // Timer rollover, masked and then enabled
    tick(300);
    chk("rtc_masked", 0, req);
    rtc_en = 1'b1;
    wait_req(300);
    chk("rtc_req", 1, req);
    irq_ack();
    rtc_en = 1'b0;
    irq_ret(1'b1);
    results();
  end
endmodule
`default_nettype wire

// File: verilog/pin_edge_sync.sv
// Purpose: Synchronise port pins and flag accepted rising and falling edges
// Assumes: Pins are asynchronous to i_sys_clk
// Notes:   A new level counts once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync #(
  parameter int WIDTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_pins,
  output logic [WIDTH-1:0] o_rise,
  output logic [WIDTH-1:0] o_fall
);

  ////////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_pin
      logic meta_q;
      logic s2_q;
      logic s3_q;
      logic level_q;
      // Stage one feeds stage two only, to keep metastability contained
      always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          meta_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          meta_q <= i_pins[gi];
          s2_q <= meta_q;
          s3_q <= s2_q;
        end
      end
      // Accepted level moves only on agreement, giving one-cycle edges
      always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          level_q <= 1'b0;
          o_rise[gi] <= 1'b0;
          o_fall[gi] <= 1'b0;
        end else begin
          o_rise[gi] <= (s2_q == s3_q) && s3_q && !level_q;
          o_fall[gi] <= (s2_q == s3_q) && !s3_q && level_q;
          if (s2_q == s3_q) begin
            level_q <= s3_q;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// File: verilog/port_edge_interrupt_wakeup_unit.sv
// Purpose: Port edge interrupts, timer rollover interrupt, wake from sleep
// Assumes: Core sequencer drives config writes, acknowledge and returns
//          as one-cycle pulses on i_sys_clk; pins are asynchronous
// Notes:   Context outputs are one-cycle load pulses with their values
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Pending register content after reset is undefined; software clears it.
// - Write with selector 09 swaps accumulator and pending register.
// - Selector 0F writes direction, 0A polarity, 0B enable.
// - Timer rollover from FF to 00 raises internal interrupt.
// - Rollover interrupt gated by option enable bit; no pending flag.
// - Eight edge sources, one per pin, shared with wake logic.
// - Per-pin enable bit: zero enables, one disables.
// - Polarity one selects falling edge, zero selects rising edge.
// - Reset loads enable and polarity registers with FF.
// - Wake pending register doubles as interrupt pending register.
// - Equal priority; after acknowledge interrupts blocked until return.
// - Acknowledge pushes PC, saves bank select, flags and accumulator.
// - After saving flags, clear the three page select bits.
// - Interrupt stack is separate from the subroutine stack.
// - Acknowledge loads the program counter with vector zero.
// - Edge during service sets pending but raises no trigger.
// - Next external trigger only after its pending bit is cleared.
// - Return restores PC, bank, flags, accumulator; reenables interrupts.
// - Variant return also adds accumulator to the real-time counter.
// - Selected edge latches a one into the pin's pending bit.
// - Wake from power-down branches program counter to top address.
module port_edge_interrupt_wakeup_unit
  import port_wake_pkg::*;
#(
  parameter int PINS = port_wake_pkg::PORT_W
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [PINS-1:0] i_port_pins,
  input wire logic i_cfg_wr,
  input wire logic [port_wake_pkg::DATA_W-1:0] i_port_sel,
  input wire logic [port_wake_pkg::DATA_W-1:0] i_acc,
  input wire logic [port_wake_pkg::DATA_W-1:0] i_bank_sel,
  input wire logic [port_wake_pkg::DATA_W-1:0] i_flags,
  input wire logic [port_wake_pkg::PC_W-1:0] i_pc,
  input wire logic [port_wake_pkg::DATA_W-1:0] i_rtc_value,
  input wire logic i_rtc_irq_en,
  input wire logic i_sleep,
  input wire logic i_irq_ack,
  input wire logic i_irq_return,
  input wire logic i_irq_return_add_acc,
  output logic o_irq_req,
  output logic o_in_service,
  output logic o_pc_load,
  output logic [port_wake_pkg::PC_W-1:0] o_pc_value,
  output logic o_flags_load,
  output logic [port_wake_pkg::DATA_W-1:0] o_flags_value,
  output logic o_ctx_restore,
  output logic [port_wake_pkg::DATA_W-1:0] o_bank_value,
  output logic [port_wake_pkg::DATA_W-1:0] o_acc_value,
  output logic o_rtc_add,
  output logic [port_wake_pkg::DATA_W-1:0] o_rtc_add_value,
  output logic o_xchg_valid,
  output logic [PINS-1:0] o_xchg_data,
  output logic o_wake,
  output logic [PINS-1:0] o_pin_wake_pending,
  output logic [PINS-1:0] o_pin_wake_enable,
  output logic [PINS-1:0] o_pin_edge_polarity,
  output logic [PINS-1:0] o_pin_dir
);
  import port_wake_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [PINS-1:0] rise;
  logic [PINS-1:0] fall;
  logic [PINS-1:0] edge_evt;
  logic [PINS-1:0] armed_evt;
  logic [PINS-1:0] pend_q;
  logic [PINS-1:0] en_n_q;
  logic [PINS-1:0] pol_q;
  logic [PINS-1:0] dir_q;
  logic [DATA_W-1:0] rtc_prev_q;
  logic rtc_roll;
  logic ext_trig;
  logic rtc_trig;
  logic any_ret;
  logic wr_xchg;
  logic [PC_W-1:0] stack_q;
  logic [DATA_W-1:0] bank_sh_q;
  logic [DATA_W-1:0] flags_sh_q;
  logic [DATA_W-1:0] acc_sh_q;
  irq_state_e state_q;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge detect, one lane per pin
  pin_edge_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_pins(i_port_pins),
    .o_rise(rise),
    .o_fall(fall)
  );

  // Polarity picks which edge counts; wake and interrupt share this
  assign edge_evt = (pol_q & fall) | (~pol_q & rise);
  // Only enabled pins whose bit is not already pending may trigger
  assign armed_evt = edge_evt & ~en_n_q & ~pend_q;
  assign wr_xchg = i_cfg_wr && (i_port_sel == SEL_PENDING_XCHG);
  assign any_ret = i_irq_return || i_irq_return_add_acc;
  // Rollover seen as FF on the previous cycle and 00 now
  assign rtc_roll = (rtc_prev_q == RTC_MAX) && (i_rtc_value == RTC_ZERO);
  assign rtc_trig = rtc_roll && i_rtc_irq_en;
  // Pin requests are not raised while asleep, the pin wakes the core instead; rollover requests still are
  assign ext_trig = (|armed_evt) && !i_sleep;

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers written through the port location
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      en_n_q <= WAKE_EN_RST[PINS-1:0];
      pol_q <= EDGE_POL_RST[PINS-1:0];
      dir_q <= PIN_DIR_RST[PINS-1:0];
    end else if (i_cfg_wr) begin
      case (i_port_sel)
        SEL_PIN_DIR: dir_q <= i_acc[PINS-1:0];
        SEL_EDGE_POL: pol_q <= i_acc[PINS-1:0];
        SEL_WAKE_EN: en_n_q <= i_acc[PINS-1:0];
        default: dir_q <= dir_q;
      endcase
    end
  end

  // Pending register; an edge in the swap cycle still lands (set wins)
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend_q <= PENDING_RST[PINS-1:0];
    end else if (wr_xchg) begin
      pend_q <= i_acc[PINS-1:0] | edge_evt;
    end else begin
      pend_q <= pend_q | edge_evt;
    end
  end

  // Old pending value handed back to the accumulator on a swap
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_xchg_valid <= 1'b0;
      o_xchg_data <= '0;
    end else begin
      o_xchg_valid <= wr_xchg;
      if (wr_xchg) begin
        o_xchg_data <= pend_q;
      end
    end
  end

  // Timer history for rollover detection; no pending bit is kept
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rtc_prev_q <= RTC_ZERO;
    end else begin
      rtc_prev_q <= i_rtc_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: one source at a time, blocked until return
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (ext_trig || rtc_trig) begin
            state_q <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (i_irq_ack) begin
            state_q <= ST_SERVICE;
          end
        end
        ST_SERVICE: begin
          if (any_ret) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Context save on acknowledge; own stack, not the call stack
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stack_q <= '0;
      bank_sh_q <= '0;
      flags_sh_q <= '0;
      acc_sh_q <= '0;
    end else if (state_q == ST_REQ && i_irq_ack) begin
      stack_q <= i_pc;
      bank_sh_q <= i_bank_sel;
      flags_sh_q <= i_flags;
      acc_sh_q <= i_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core-facing pulses and values, all registered
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pc_load <= 1'b0;
      o_pc_value <= RESET_VECTOR;
      o_flags_load <= 1'b0;
      o_flags_value <= '0;
      o_ctx_restore <= 1'b0;
      o_bank_value <= '0;
      o_acc_value <= '0;
      o_rtc_add <= 1'b0;
      o_rtc_add_value <= '0;
      o_wake <= 1'b0;
    end else begin
      o_pc_load <= 1'b0;
      o_flags_load <= 1'b0;
      o_ctx_restore <= 1'b0;
      o_rtc_add <= 1'b0;
      o_wake <= 1'b0;
      if (i_sleep && (|(edge_evt & ~en_n_q))) begin
        o_wake <= 1'b1;
        o_pc_load <= 1'b1;
        o_pc_value <= RESET_VECTOR;
      end else if (state_q == ST_REQ && i_irq_ack) begin
        o_pc_load <= 1'b1;
        o_pc_value <= IRQ_VECTOR;
        o_flags_load <= 1'b1;
        o_flags_value <= i_flags & ~PAGE_SEL_MASK;
      end else if (state_q == ST_SERVICE && any_ret) begin
        o_pc_load <= 1'b1;
        o_pc_value <= stack_q;
        o_flags_load <= 1'b1;
        o_flags_value <= flags_sh_q;
        o_ctx_restore <= 1'b1;
        o_bank_value <= bank_sh_q;
        o_acc_value <= acc_sh_q;
        // Added value is the accumulator as it stood at the return
        o_rtc_add <= i_irq_return_add_acc;
        o_rtc_add_value <= i_acc;
      end
    end
  end

  // Status mirrors for the core
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq_req <= 1'b0;
      o_in_service <= 1'b0;
      o_pin_wake_pending <= PENDING_RST[PINS-1:0];
      o_pin_wake_enable <= WAKE_EN_RST[PINS-1:0];
      o_pin_edge_polarity <= EDGE_POL_RST[PINS-1:0];
      o_pin_dir <= PIN_DIR_RST[PINS-1:0];
    end else begin
      o_irq_req <= (state_q == ST_IDLE && (ext_trig || rtc_trig)) ||
                   (state_q == ST_REQ && !i_irq_ack);
      o_in_service <= (state_q == ST_REQ && i_irq_ack) ||
                      (state_q == ST_SERVICE && !any_ret);
      o_pin_wake_pending <= pend_q;
      o_pin_wake_enable <= en_n_q;
      o_pin_edge_polarity <= pol_q;
      o_pin_dir <= dir_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence ack_seq;
    state_q == ST_REQ && i_irq_ack && !i_sleep;
  endsequence

  sequence ret_seq;
    state_q == ST_SERVICE && any_ret && !i_sleep;
  endsequence

  pending_swap_a: assert property (wr_xchg |=>
    pend_q == ($past(i_acc[PINS-1:0]) | $past(edge_evt)) &&
    o_xchg_data == $past(pend_q) && o_xchg_valid)
    else $error("pending swap wrong");

  polarity_write_a: assert property (
    i_cfg_wr && i_port_sel == SEL_EDGE_POL |=> pol_q == $past(i_acc))
    else $error("polarity write lost");

  rollover_req_a: assert property (
    state_q == ST_IDLE && rtc_trig |=> o_irq_req && state_q == ST_REQ)
    else $error("rollover request missing");

  rollover_gate_a: assert property (
    state_q == ST_IDLE && !ext_trig && !(rtc_roll && i_rtc_irq_en)
    |=> !o_irq_req)
    else $error("ungated request");

  pending_latch_a: assert property (
    |edge_evt |=> (pend_q & $past(edge_evt)) == $past(edge_evt))
    else $error("edge not latched");

  service_block_a: assert property (
    o_in_service |-> !o_irq_req)
    else $error("request while in service");

  ack_vector_a: assert property (ack_seq |=>
    o_pc_load && o_pc_value == IRQ_VECTOR && o_in_service)
    else $error("vector load wrong");

  page_clear_a: assert property (ack_seq |=>
    o_flags_load && o_flags_value == ($past(i_flags) & ~PAGE_SEL_MASK)
    && flags_sh_q == $past(i_flags))
    else $error("page bits not cleared");

  return_restore_a: assert property (ret_seq |=>
    o_ctx_restore && o_pc_value == $past(stack_q) &&
    o_acc_value == $past(acc_sh_q) && !o_in_service)
    else $error("return restore wrong");

  return_add_a: assert property (
    ret_seq and i_irq_return_add_acc |=> o_rtc_add &&
    o_rtc_add_value == $past(i_acc))
    else $error("timer add missing");

  wake_branch_a: assert property (
    i_sleep && |(edge_evt & ~en_n_q) |=>
    o_wake && o_pc_load && o_pc_value == RESET_VECTOR)
    else $error("wake branch wrong");

endmodule
`default_nettype wire
